//--- include/ssc_pkg.sv
// package: offsets, bit positions, reset values and codes of the status condition bank
package ssc_pkg;
  localparam int unsigned REG_W = 16;

  // register selectors on the query port
  localparam logic [2:0] SEL_OP_COND   = 3'h0;
  localparam logic [2:0] SEL_OP_EVENT  = 3'h1;
  localparam logic [2:0] SEL_OP_ENABLE = 3'h2;
  localparam logic [2:0] SEL_QS_COND   = 3'h3;
  localparam logic [2:0] SEL_QS_EVENT  = 3'h4;
  localparam logic [2:0] SEL_QS_ENABLE = 3'h5;

  // operation condition bit positions
  localparam int unsigned OP_WTG_BIT      = 5;
  localparam int unsigned OP_ARMED_BIT    = 6;
  localparam int unsigned OP_CV_BIT       = 8;
  localparam int unsigned OP_TRAN_DONE_BIT = 9;
  localparam int unsigned OP_CC_BIT       = 10;
  localparam int unsigned OP_SAMPLE_BIT   = 11;
  localparam int unsigned OP_LIST_DONE_BIT = 12;
  localparam int unsigned OP_LIST_RUN_BIT = 14;

  // questionable condition bit positions
  localparam int unsigned QS_VMODE_BIT  = 0;
  localparam int unsigned QS_CMODE_BIT  = 1;
  localparam int unsigned QS_THERM_BIT  = 3;
  localparam int unsigned QS_SLAVE_BIT  = 6;
  localparam int unsigned QS_VPROT_BIT  = 12;
  localparam int unsigned QS_CPROT_BIT  = 13;
  localparam int unsigned QS_SINK_BIT   = 14;

  // masks of the unused and hidden condition bits
  localparam logic [15:0] OP_UNUSED_MASK = 16'hA09F;
  localparam logic [15:0] OP_HIDDEN_MASK = 16'h1200;
  localparam logic [15:0] QS_UNUSED_MASK = 16'h8FB4;

  // reset values
  localparam logic [15:0] COND_RST   = 16'h0000;
  localparam logic [15:0] EVENT_RST  = 16'h0000;
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [15:0] RDATA_RST  = 16'h0000;

  // synchronised pin vector layout
  localparam int unsigned PIN_W       = 6;
  localparam int unsigned PIN_TRIG    = 0;
  localparam int unsigned PIN_THERM   = 1;
  localparam int unsigned PIN_SLAVE   = 2;
  localparam int unsigned PIN_VPROT   = 3;
  localparam int unsigned PIN_CPROT   = 4;
  localparam int unsigned PIN_SINK    = 5;
  localparam logic [5:0]  PIN_RST     = 6'h01;

  // hardware error code pushed on a failed circuit check
  localparam logic [7:0] HW_ERR_CODE = 8'h18;
endpackage

//--- design/ssc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ssc_pin_sync #(
  parameter int unsigned         W       = 1,
  parameter logic [W-1:0]        RST_VAL = '0
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic out_q;
      wire  agree = (s2_q == s3_q);
      always_ff @(posedge ref_clk_in)
      begin
        if (!rst_b_in)
        begin
          s1_q  <= RST_VAL[gi];
          s2_q  <= RST_VAL[gi];
          s3_q  <= RST_VAL[gi];
          out_q <= RST_VAL[gi];
        end
        else if (ce_in)
        begin
          s1_q <= pin_in[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (agree)
          begin
            out_q <= s3_q;
          end
        end
      end
      assign sync_out[gi] = out_q;
    end
  endgenerate
endmodule // ssc_pin_sync

//--- design/ssc_status_bank.sv
// operation and questionable status condition, event and enable registers
//
// Overview of operation
// - operation bits 0-4, 7, 13, 15 always read zero.
// - operation bit 5 set while trigger system enabled and waiting.
// - external trigger held low keeps awaiting-trigger bit one until input high.
// - operation bit 6 set while transient function armed.
// - operation bit 8 set in constant voltage mode.
// - transient complete on bit 9, hidden from condition reads, seen via events.
// - operation bit 10 set in constant current mode.
// - operation bit 11 set once sample acquisition finished.
// - list complete on bit 12, hidden from condition reads.
// - operation bit 14 set while programmed list runs.
// - questionable bit 0 set when operating in current mode.
// - questionable bit 1 set when operating in voltage mode.
// - questionable bit 3 set on thermal fault.
// - questionable bit 6 set on slave fault in master/slave use.
// - questionable bit 12 set on voltage protection error.
// - questionable bit 13 set on current protection error.
// - with external reference, any protection error sets bits 12 and 13.
// - questionable bit 14 set while sinking energy from the load.
// - questionable bits 2, 4, 5, 7-11, 15 always read zero.
// - failed calibration circuit check beeps and queues hardware error.
// - each zero-to-one condition transition sets matching event bit.
// - reading an event register clears all its bits except those set in the same cycle.
// - both registers 16 bits, each with event and enable registers.
`timescale 1ns/1ps
module ssc_status_bank (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  // same-clock status sources
  input  wire logic        trig_enabled_in,
  input  wire logic        trig_src_ext_in,
  input  wire logic        tran_armed_in,
  input  wire logic        cv_mode_in,
  input  wire logic        cc_mode_in,
  input  wire logic        tran_done_in,
  input  wire logic        sample_done_in,
  input  wire logic        list_done_in,
  input  wire logic        list_running_in,
  input  wire logic        ext_ref_en_in,
  input  wire logic        cal_check_fail_in,
  // pins from outside the clock domain
  input  wire logic        trig_pin_in,
  input  wire logic        thermal_fault_in,
  input  wire logic        slave_fault_in,
  input  wire logic        vprot_err_in,
  input  wire logic        cprot_err_in,
  input  wire logic        sinking_in,
  // status query port
  input  wire logic        rd_strobe_in,
  input  wire logic [2:0]  rd_sel_in,
  input  wire logic        wr_strobe_in,
  input  wire logic [2:0]  wr_sel_in,
  input  wire logic [15:0] wr_data_in,
  output logic      [15:0] rd_data_out,
  output logic             rd_valid_out,
  // summaries and calibration error reporting
  output logic             op_summary_out,
  output logic             qs_summary_out,
  output logic             beep_out,
  output logic             err_push_out,
  output logic      [7:0]  err_code_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // pin synchronisation
  logic [ssc_pkg::PIN_W-1:0] pin_raw;
  logic [ssc_pkg::PIN_W-1:0] pin_s;

  assign pin_raw[ssc_pkg::PIN_TRIG]  = trig_pin_in;
  assign pin_raw[ssc_pkg::PIN_THERM] = thermal_fault_in;
  assign pin_raw[ssc_pkg::PIN_SLAVE] = slave_fault_in;
  assign pin_raw[ssc_pkg::PIN_VPROT] = vprot_err_in;
  assign pin_raw[ssc_pkg::PIN_CPROT] = cprot_err_in;
  assign pin_raw[ssc_pkg::PIN_SINK]  = sinking_in;

  ssc_pin_sync #(
    .W       (ssc_pkg::PIN_W),
    .RST_VAL (ssc_pkg::PIN_RST)
  ) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .ce_in      (ce_in),
    .pin_in     (pin_raw),
    .sync_out   (pin_s)
  );

  // registers
  logic [15:0] op_cond_q;
  logic [15:0] op_cond_d;
  logic [15:0] op_ev_q;
  logic [15:0] op_ev_d;
  logic [15:0] op_en_q;
  logic [15:0] qs_cond_q;
  logic [15:0] qs_cond_d;
  logic [15:0] qs_ev_q;
  logic [15:0] qs_ev_d;
  logic [15:0] qs_en_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        rvalid_q;
  logic        wtg_q;
  logic        tran_done_q;
  logic        list_done_q;
  logic        beep_q;
  logic        err_push_q;
  logic [7:0]  err_code_q;

  // completion pulses on the rising edge of the done levels
  wire tran_pulse = tran_done_in & ~tran_done_q;
  wire list_pulse = list_done_in & ~list_done_q;

  // awaiting trigger flag
  wire trig_pin_low = ~pin_s[ssc_pkg::PIN_TRIG];
  wire wtg_d        = trig_enabled_in | (wtg_q & trig_src_ext_in & trig_pin_low);

  // protection errors, paired under external reference
  wire prot_any = pin_s[ssc_pkg::PIN_VPROT] | pin_s[ssc_pkg::PIN_CPROT];
  wire vprot_b  = pin_s[ssc_pkg::PIN_VPROT] | (ext_ref_en_in & prot_any);
  wire cprot_b  = pin_s[ssc_pkg::PIN_CPROT] | (ext_ref_en_in & prot_any);

  // next operation condition
  always_comb
  begin
    op_cond_d                                = ssc_pkg::COND_RST;
    op_cond_d[ssc_pkg::OP_WTG_BIT]           = wtg_d;
    op_cond_d[ssc_pkg::OP_ARMED_BIT]         = tran_armed_in;
    op_cond_d[ssc_pkg::OP_CV_BIT]            = cv_mode_in;
    op_cond_d[ssc_pkg::OP_TRAN_DONE_BIT]     = tran_pulse;
    op_cond_d[ssc_pkg::OP_CC_BIT]            = cc_mode_in;
    op_cond_d[ssc_pkg::OP_SAMPLE_BIT]        = sample_done_in;
    op_cond_d[ssc_pkg::OP_LIST_DONE_BIT]     = list_pulse;
    op_cond_d[ssc_pkg::OP_LIST_RUN_BIT]      = list_running_in;
  end

  // next questionable condition
  always_comb
  begin
    qs_cond_d                           = ssc_pkg::COND_RST;
    qs_cond_d[ssc_pkg::QS_VMODE_BIT]    = cc_mode_in;
    qs_cond_d[ssc_pkg::QS_CMODE_BIT]    = cv_mode_in;
    qs_cond_d[ssc_pkg::QS_THERM_BIT]    = pin_s[ssc_pkg::PIN_THERM];
    qs_cond_d[ssc_pkg::QS_SLAVE_BIT]    = pin_s[ssc_pkg::PIN_SLAVE];
    qs_cond_d[ssc_pkg::QS_VPROT_BIT]    = vprot_b;
    qs_cond_d[ssc_pkg::QS_CPROT_BIT]    = cprot_b;
    qs_cond_d[ssc_pkg::QS_SINK_BIT]     = pin_s[ssc_pkg::PIN_SINK];
  end

  // query decode
  wire rd_op_ev = rd_strobe_in & (rd_sel_in == ssc_pkg::SEL_OP_EVENT);
  wire rd_qs_ev = rd_strobe_in & (rd_sel_in == ssc_pkg::SEL_QS_EVENT);
  wire wr_op_en = wr_strobe_in & (wr_sel_in == ssc_pkg::SEL_OP_ENABLE);
  wire wr_qs_en = wr_strobe_in & (wr_sel_in == ssc_pkg::SEL_QS_ENABLE);

  // rising transitions; set wins over read-clear
  wire [15:0] op_rise = op_cond_d & ~op_cond_q;
  wire [15:0] qs_rise = qs_cond_d & ~qs_cond_q;
  assign op_ev_d = (rd_op_ev ? ssc_pkg::EVENT_RST : op_ev_q) | op_rise;
  assign qs_ev_d = (rd_qs_ev ? ssc_pkg::EVENT_RST : qs_ev_q) | qs_rise;

  // readable condition values
  wire [15:0] op_cond_rd = op_cond_q & ~ssc_pkg::OP_HIDDEN_MASK & ~ssc_pkg::OP_UNUSED_MASK;
  wire [15:0] qs_cond_rd = qs_cond_q & ~ssc_pkg::QS_UNUSED_MASK;

  // read multiplexer
  always_comb
  begin
    unique case (rd_sel_in)
      ssc_pkg::SEL_OP_COND:   rdata_d = op_cond_rd;
      ssc_pkg::SEL_OP_EVENT:  rdata_d = op_ev_q;
      ssc_pkg::SEL_OP_ENABLE: rdata_d = op_en_q;
      ssc_pkg::SEL_QS_COND:   rdata_d = qs_cond_rd;
      ssc_pkg::SEL_QS_EVENT:  rdata_d = qs_ev_q;
      ssc_pkg::SEL_QS_ENABLE: rdata_d = qs_en_q;
      default:                rdata_d = ssc_pkg::RDATA_RST;
    endcase
  end

  // condition and event state
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      op_cond_q   <= ssc_pkg::COND_RST;
      qs_cond_q   <= ssc_pkg::COND_RST;
      op_ev_q     <= ssc_pkg::EVENT_RST;
      qs_ev_q     <= ssc_pkg::EVENT_RST;
      wtg_q       <= 1'b0;
      tran_done_q <= 1'b0;
      list_done_q <= 1'b0;
    end
    else if (ce_in)
    begin
      op_cond_q   <= op_cond_d;
      qs_cond_q   <= qs_cond_d;
      op_ev_q     <= op_ev_d;
      qs_ev_q     <= qs_ev_d;
      wtg_q       <= wtg_d;
      tran_done_q <= tran_done_in;
      list_done_q <= list_done_in;
    end
  end

  // enable masks and query answer
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      op_en_q  <= ssc_pkg::ENABLE_RST;
      qs_en_q  <= ssc_pkg::ENABLE_RST;
      rdata_q  <= ssc_pkg::RDATA_RST;
      rvalid_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (wr_op_en)
      begin
        op_en_q <= wr_data_in;
      end
      if (wr_qs_en)
      begin
        qs_en_q <= wr_data_in;
      end
      rvalid_q <= rd_strobe_in;
      if (rd_strobe_in)
      begin
        rdata_q <= rdata_d;
      end
    end
  end

  // calibration check failure reporting
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      beep_q     <= 1'b0;
      err_push_q <= 1'b0;
      err_code_q <= 8'h00;
    end
    else if (ce_in)
    begin
      beep_q     <= cal_check_fail_in;
      err_push_q <= cal_check_fail_in;
      if (cal_check_fail_in)
      begin
        err_code_q <= ssc_pkg::HW_ERR_CODE;
      end
    end
  end

  assign rd_data_out    = rdata_q;
  assign rd_valid_out   = rvalid_q;
  assign op_summary_out = |(op_ev_q & op_en_q);
  assign qs_summary_out = |(qs_ev_q & qs_en_q);
  assign beep_out       = beep_q;
  assign err_push_out   = err_push_q;
  assign err_code_out   = err_code_q;

  // checks
  a_op_unused_zero: assert property ((op_cond_q & ssc_pkg::OP_UNUSED_MASK) == 16'h0000)
    else $error("unused operation bit reads one");

  a_wtg_set: assert property (ce_in && trig_enabled_in |=> op_cond_q[5])
    else $error("awaiting trigger bit not set");

  a_wtg_hold_low: assert property (ce_in && op_cond_q[5] && wtg_q && trig_src_ext_in
                                   && !pin_s[0] |=> op_cond_q[5])
    else $error("awaiting trigger bit dropped while pin low");

  a_cv_cc_track: assert property (ce_in |=> (op_cond_q[8] == $past(cv_mode_in))
                                  && (qs_cond_q[1] == $past(cv_mode_in))
                                  && (op_cond_q[10] == $past(cc_mode_in)))
    else $error("mode bits do not follow regulation mode");

  a_done_hidden: assert property (rd_strobe_in && ce_in && rd_sel_in == 3'h0
                                  |=> rd_valid_out && rd_data_out[9] == 1'b0
                                  && rd_data_out[12] == 1'b0)
    else $error("completion bit visible in condition read");

  a_done_pulse: assert property (ce_in && tran_pulse ##1 ce_in |-> !tran_pulse)
    else $error("transient completion pulse longer than one cycle");

  a_done_capture: assert property (ce_in && list_pulse |=> op_ev_q[12] ##1 1'b1)
    else $error("list completion not captured");

  a_event_capture: assert property (ce_in && qs_rise != 16'h0000
                                    |=> (qs_ev_q & $past(qs_rise)) == $past(qs_rise))
    else $error("rising condition not captured in event");

  a_event_clear: assert property (ce_in && rd_op_ev && op_rise == 16'h0000
                                  |=> op_ev_q == 16'h0000)
    else $error("event register not cleared by read");

  a_prot_pair: assert property (ce_in && ext_ref_en_in && prot_any
                                |=> qs_cond_q[12] && qs_cond_q[13])
    else $error("protection bits not paired under external reference");

  a_qs_unused_zero: assert property (ce_in |=> (qs_cond_q & ssc_pkg::QS_UNUSED_MASK) == 16'h0000)
    else $error("unused questionable bit set");

  a_cal_beep: assert property (ce_in && cal_check_fail_in
                               |=> beep_out && err_push_out
                               && err_code_out == ssc_pkg::HW_ERR_CODE)
    else $error("failed circuit check not reported");
endmodule // ssc_status_bank

//--- testbench/ssc_host_model.sv
// remote host model issuing status queries and enable writes
`timescale 1ns/1ps
module ssc_host_model (
  input  wire logic        ref_clk_in,
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in,
  output logic             rd_strobe_out,
  output logic      [2:0]  rd_sel_out,
  output logic             wr_strobe_out,
  output logic      [2:0]  wr_sel_out,
  output logic      [15:0] wr_data_out
);
  initial
  begin
    rd_strobe_out = 1'b0;
    rd_sel_out    = 3'h7;
    wr_strobe_out = 1'b0;
    wr_sel_out    = 3'h7;
    wr_data_out   = 16'h0000;
  end

  // one read query, answer awaited for a bounded count
  task automatic rd(input logic [2:0] s, output logic [15:0] d);
    int i;
    @(posedge ref_clk_in);
    rd_strobe_out <= 1'b1;
    rd_sel_out    <= s;
    @(posedge ref_clk_in);
    rd_strobe_out <= 1'b0;
    rd_sel_out    <= ~s;
    #1;
    for (i = 0; i < 4 && rd_valid_in !== 1'b1; i++)
    begin
      @(posedge ref_clk_in);
      #1;
    end
    d = (rd_valid_in === 1'b1) ? rd_data_in : 16'hxxxx;
  endtask

  // one write query, released lines show inverted data
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge ref_clk_in);
    wr_strobe_out <= 1'b1;
    wr_sel_out    <= s;
    wr_data_out   <= d;
    @(posedge ref_clk_in);
    wr_strobe_out <= 1'b0;
    wr_sel_out    <= ~s;
    wr_data_out   <= ~d;
  endtask
endmodule // ssc_host_model

//--- testbench/ssc_status_bank_test.sv
// self-checking bench of the status condition bank
`timescale 1ns/1ps
module ssc_status_bank_test;
  logic        ref_clk_in = 1'b0;
  logic        rst_b_in   = 1'b0;
  logic        trg_en = 0, trg_ext = 0, armed = 0, cv = 0, cc = 0, tdone = 0;
  logic        samp = 0, ldone = 0, lrun = 0, xref = 0, calf = 0, tpin = 1;
  logic        therm = 0, slv = 0, vp = 0, cp = 0, sink = 0, wtg_hold = 0;
  logic        ce = 1;
  logic [15:0] rd_data, wr_data, d, op_en, qs_en, qs_old;
  logic [2:0]  rd_sel, wr_sel;
  logic        rd_valid, rd_strobe, wr_strobe, op_sum, qs_sum, beep, push;
  logic [7:0]  code;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          i;

  always #5 ref_clk_in = ~ref_clk_in;

  ssc_host_model host (.ref_clk_in(ref_clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
    .rd_strobe_out(rd_strobe), .rd_sel_out(rd_sel), .wr_strobe_out(wr_strobe),
    .wr_sel_out(wr_sel), .wr_data_out(wr_data));

  ssc_status_bank dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .ce_in(ce),
    .trig_enabled_in(trg_en), .trig_src_ext_in(trg_ext), .tran_armed_in(armed),
    .cv_mode_in(cv), .cc_mode_in(cc), .tran_done_in(tdone), .sample_done_in(samp),
    .list_done_in(ldone), .list_running_in(lrun), .ext_ref_en_in(xref),
    .cal_check_fail_in(calf), .trig_pin_in(tpin), .thermal_fault_in(therm),
    .slave_fault_in(slv), .vprot_err_in(vp), .cprot_err_in(cp), .sinking_in(sink),
    .rd_strobe_in(rd_strobe), .rd_sel_in(rd_sel), .wr_strobe_in(wr_strobe),
    .wr_sel_in(wr_sel), .wr_data_in(wr_data), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .op_summary_out(op_sum), .qs_summary_out(qs_sum),
    .beep_out(beep), .err_push_out(push), .err_code_out(code));

  // reference model of the readable condition words
  function automatic logic [15:0] op_exp();
    op_exp = 16'h0000;
    op_exp[5]  = trg_en | wtg_hold;
    op_exp[6]  = armed;
    op_exp[8]  = cv;
    op_exp[10] = cc;
    op_exp[11] = samp;
    op_exp[14] = lrun;
  endfunction

  function automatic logic [15:0] qs_exp();
    qs_exp = 16'h0000;
    qs_exp[0]  = cc;
    qs_exp[1]  = cv;
    qs_exp[3]  = therm;
    qs_exp[6]  = slv;
    qs_exp[12] = vp | (xref & (vp | cp));
    qs_exp[13] = cp | (xref & (vp | cp));
    qs_exp[14] = sink;
  endfunction

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'hf5268b35));
    repeat (4) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    // reset values and unmapped selectors
    for (i = 0; i < 8; i++)
    begin
      host.rd(3'(i), d);
      chk("reset read", d, 16'h0000);
    end
    $display("test reset done");
    // enable masks writable, operation condition and questionable event registers read-only
    op_en = 16'($urandom) | 16'h1200;
    host.wr(ssc_pkg::SEL_OP_ENABLE, op_en);
    qs_en = 16'($urandom) | 16'h0008;
    host.wr(ssc_pkg::SEL_QS_ENABLE, qs_en);
    host.wr(ssc_pkg::SEL_OP_COND, 16'hffff);
    host.wr(ssc_pkg::SEL_QS_EVENT, 16'hffff);
    host.rd(ssc_pkg::SEL_OP_ENABLE, d);
    chk("op enable", d, op_en);
    host.rd(ssc_pkg::SEL_QS_ENABLE, d);
    chk("qs enable", d, qs_en);
    host.rd(ssc_pkg::SEL_OP_COND, d);
    chk("op cond ro", d, 16'h0000);
    host.rd(ssc_pkg::SEL_QS_EVENT, d);
    chk("qs event ro", d, 16'h0000);
    $display("test registers done");
    // random same-clock status levels
    for (i = 0; i < 8; i++)
    begin
      @(posedge ref_clk_in);
      {trg_en, armed, cv, cc, samp, lrun} <= 6'($urandom);
      repeat (2) @(posedge ref_clk_in);
      host.rd(ssc_pkg::SEL_OP_COND, d);
      chk("op cond", d, op_exp());
      host.rd(ssc_pkg::SEL_QS_COND, d);
      chk("qs cond", d, qs_exp());
    end
    $display("test levels done");
    // completion pulses seen only through events
    host.rd(ssc_pkg::SEL_OP_EVENT, d);
    @(posedge ref_clk_in);
    tdone <= 1'b1;
    ldone <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    host.rd(ssc_pkg::SEL_OP_COND, d);
    chk("op cond hidden", d, op_exp());
    chk("op summary", 16'(op_sum), 16'h0001);
    host.rd(ssc_pkg::SEL_OP_EVENT, d);
    chk("op event", d, 16'h1200);
    host.rd(ssc_pkg::SEL_OP_EVENT, d);
    chk("op event clear", d, 16'h0000);
    chk("op summary clear", 16'(op_sum), 16'h0000);
    $display("test completion done");
    // asynchronous fault pins
    host.rd(ssc_pkg::SEL_QS_EVENT, d);
    qs_old = qs_exp();
    @(posedge ref_clk_in);
    {therm, slv, vp, sink} <= 4'hf;
    repeat (8) @(posedge ref_clk_in);
    host.rd(ssc_pkg::SEL_QS_COND, d);
    chk("qs faults", d, qs_exp());
    chk("qs summary", 16'(qs_sum), 16'h0001);
    host.rd(ssc_pkg::SEL_QS_EVENT, d);
    chk("qs event", d, qs_exp() & ~qs_old);
    chk("qs summary clear", 16'(qs_sum), 16'h0000);
    @(posedge ref_clk_in);
    vp   <= 1'b0;
    cp   <= 1'b1;
    xref <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    host.rd(ssc_pkg::SEL_QS_COND, d);
    chk("qs ext ref", d, qs_exp());
    $display("test faults done");
    // awaiting-trigger held by low external trigger pin
    @(posedge ref_clk_in);
    trg_ext <= 1'b1;
    trg_en  <= 1'b1;
    tpin    <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    trg_en   <= 1'b0;
    wtg_hold <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    host.rd(ssc_pkg::SEL_OP_COND, d);
    chk("wtg held", d, op_exp());
    @(posedge ref_clk_in);
    tpin     <= 1'b1;
    wtg_hold <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    host.rd(ssc_pkg::SEL_OP_COND, d);
    chk("wtg released", d, op_exp());
    $display("test trigger done");
    // failed calibration check, first with the clock enable low
    @(posedge ref_clk_in);
    ce   <= 1'b0;
    calf <= 1'b1;
    @(posedge ref_clk_in);
    calf <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    chk("frozen beep", 16'(beep), 16'h0000);
    @(posedge ref_clk_in);
    ce <= 1'b1;
    @(posedge ref_clk_in);
    calf <= 1'b1;
    @(posedge ref_clk_in);
    calf <= 1'b0;
    #1;
    chk("beep", 16'(beep), 16'h0001);
    chk("err push", 16'(push), 16'h0001);
    chk("err code", 16'(code), 16'(ssc_pkg::HW_ERR_CODE));
    @(posedge ref_clk_in);
    #1;
    chk("beep end", 16'(beep), 16'h0000);
    $display("test calibration done");
    report_and_stop();
  end
endmodule // ssc_status_bank_test
